//--- design/mfm_pkg.sv
// Purpose: shared constants for the motion fault monitor
// Assumes: error codes fit in eight bits
// Notes:   timing counts derive from the 20 MHz system clock
package mfm_pkg;
  localparam logic [7:0] MFM_CODE_NONE    = 8'h00;
  localparam logic [7:0] MFM_CODE_PWRON   = 8'h1a;  // 26
  localparam logic [7:0] MFM_CODE_MOTTEMP = 8'h1d;  // 29
  localparam logic [7:0] MFM_CODE_LIMIT   = 8'h1e;  // 30
  localparam logic [7:0] MFM_CODE_DUPLAB  = 8'h21;  // 33
  localparam logic [7:0] MFM_CODE_FUSE    = 8'h23;  // 35
  localparam logic [7:0] MFM_CODE_LABEL   = 8'h24;  // 36
  localparam logic [7:0] MFM_CODE_SEQLINE = 8'h25;  // 37
  localparam logic [7:0] MFM_CODE_REGNUM  = 8'h26;  // 38
  localparam logic [7:0] MFM_CODE_STACK   = 8'h27;  // 39
  localparam logic [7:0] MFM_CODE_PARAMA  = 8'h28;  // 40
  localparam logic [7:0] MFM_CODE_PARAMB  = 8'h29;  // 41
  localparam logic [7:0] MFM_CODE_BUSTMO  = 8'h38;  // 56
  localparam logic [7:0] MFM_CODE_NODEDUP = 8'h3b;  // 59
  localparam logic [9:0]  MFM_LABEL_MAX   = 10'h1ff;   // 511
  localparam logic [13:0] MFM_LINE_MAX    = 14'h1ffe;  // 8190
  localparam logic [8:0]  MFM_STACK_DEPTH = 9'h100;    // 256
  localparam int MFM_LIMIT_EN_BIT  = 0;  // limit switch cfg bit
  localparam int MFM_BUSTMO_EN_BIT = 1;  // aux fault cfg bit
  localparam int MFM_CLK_HZ        = 20000000;
  localparam int MFM_BUS_TMO_US    = 1000;  // bus silence timeout
  localparam int MFM_BUS_TMO_CYC   = MFM_BUS_TMO_US * (MFM_CLK_HZ / 1000000);
endpackage

//--- design/mfm_motion_fault_monitor.sv
// Purpose: detect controller faults, latch one error code, drive brake request
// Assumes: interpreter, parameter and bus strobes are on clk_sys; pins are not
// Notes:   first fault wins; code holds until its required reset type
// Contract
// - power-on request with input one low and check cfg zero gives code 26
// - motor overtemperature on the configured input gives code 29
// - limit switch during move, cfg bit 0 set, not homing/search, gives 30
// - duplicate label definition gives code 33, cleared by software reset
// - broken encoder fuse gives code 35, cleared by software reset
// - jump or call to label above 511 gives code 36
// - executing a line number above 8190 gives code 37
// - register number above its group maximum gives code 38
// - call stack beyond 256 entries gives 39, hardware reset only
// - bad first checked parameter gives 40, brake on, hardware reset only
// - bad second checked parameter gives 41, brake on, hardware reset only
// - bus commands stop while aux cfg bit 1 set gives code 56
// - duplicated node number on the bus gives 59 and brake on
`timescale 1ns/10ps
`default_nettype none
module mfm_motion_fault_monitor
  import mfm_pkg::*;
#(
  parameter int BUS_TMO_CYC = MFM_BUS_TMO_CYC
) (
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        sw_reset,
  // pins, asynchronous
  input  wire logic        digital_input_one,
  input  wire logic [7:0]  din_pins,
  input  wire logic        limit_switch_pin,
  input  wire logic        fuse_broken_pin,
  // configuration
  input  wire logic        power_on_input_check_cfg,
  input  wire logic [7:0]  limit_switch_cfg,
  input  wire logic [7:0]  aux_fault_cfg,
  input  wire logic [2:0]  motor_temp_din_sel,
  // motion and power
  input  wire logic        power_on_req,
  input  wire logic        move_active,
  input  wire logic        index_homing_move,
  input  wire logic        stop_limit_search_move,
  // sequence interpreter
  input  wire logic        label_dup_def,
  input  wire logic        jump_call_stb,
  input  wire logic [15:0] jump_label,
  input  wire logic        exec_stb,
  input  wire logic [15:0] exec_line,
  input  wire logic        reg_access_stb,
  input  wire logic [15:0] reg_number,
  input  wire logic [15:0] reg_group_max,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  // parameters and bus
  input  wire logic        checked_param_a_bad,
  input  wire logic        checked_param_b_bad,
  input  wire logic        bus_cmd_stb,
  input  wire logic        bus_node_dup,
  // status
  output logic [7:0]       error_code,
  output logic             fault_active,
  output logic             brake_engage,
  output logic             hw_reset_needed
);
  // pin synchronisers: first stage feeds only the second
  logic [10:0] sync1_ff;
  logic [10:0] sync2_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_ff <= 11'h000;
      sync2_ff <= 11'h000;
    end else begin
      sync1_ff <= {fuse_broken_pin, limit_switch_pin, digital_input_one, din_pins};
      sync2_ff <= sync1_ff;
    end
  end
  logic       s_fuse;
  logic       s_limit;
  logic       s_digital_input_one;
  logic [7:0] s_din;
  assign {s_fuse, s_limit, s_digital_input_one, s_din} = sync2_ff;

  // stack depth and bus silence tracking
  logic [8:0]  depth_ff;
  logic [8:0]  nxt_depth;
  logic [31:0] tmo_ff;
  logic [31:0] nxt_tmo;
  always_comb begin
    nxt_depth = depth_ff;
    if (sw_reset) begin
      nxt_depth = 9'h000;
    end else if (stack_push && !stack_pop && depth_ff <= MFM_STACK_DEPTH) begin
      nxt_depth = depth_ff + 9'h001;
    end else if (stack_pop && !stack_push && depth_ff != 9'h000) begin
      nxt_depth = depth_ff - 9'h001;
    end
    nxt_tmo = tmo_ff;
    if (bus_cmd_stb || !aux_fault_cfg[MFM_BUSTMO_EN_BIT]) begin
      nxt_tmo = 32'h0000_0000;
    end else if (tmo_ff < 32'(BUS_TMO_CYC)) begin
      nxt_tmo = tmo_ff + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      depth_ff <= 9'h000;
      tmo_ff   <= 32'h0000_0000;
    end else begin
      depth_ff <= nxt_depth;
      tmo_ff   <= nxt_tmo;
    end
  end

  // fault detection in priority order, hardware-reset faults first
  logic [7:0] det_code;
  logic       det_hw;
  logic       det_brake;
  always_comb begin
    det_code  = MFM_CODE_NONE;
    det_hw    = 1'b0;
    det_brake = 1'b0;
    if (checked_param_a_bad) begin
      det_code = MFM_CODE_PARAMA;
      det_hw = 1'b1;
      det_brake = 1'b1;
    end else if (checked_param_b_bad) begin
      det_code = MFM_CODE_PARAMB;
      det_hw = 1'b1;
      det_brake = 1'b1;
    end else if (stack_push && depth_ff >= MFM_STACK_DEPTH) begin
      det_code = MFM_CODE_STACK;
      det_hw = 1'b1;
    end else if (bus_node_dup) begin
      det_code = MFM_CODE_NODEDUP;
      det_brake = 1'b1;
    end else if (power_on_req && !s_digital_input_one && !power_on_input_check_cfg) begin
      det_code = MFM_CODE_PWRON;
    end else if (s_din[motor_temp_din_sel]) begin
      det_code = MFM_CODE_MOTTEMP;
    end else if (limit_switch_cfg[MFM_LIMIT_EN_BIT] && s_limit && move_active
                 && !index_homing_move && !stop_limit_search_move) begin
      det_code = MFM_CODE_LIMIT;
    end else if (label_dup_def) begin
      det_code = MFM_CODE_DUPLAB;
    end else if (s_fuse) begin
      det_code = MFM_CODE_FUSE;
    end else if (jump_call_stb && jump_label > 16'(MFM_LABEL_MAX)) begin
      det_code = MFM_CODE_LABEL;
    end else if (exec_stb && exec_line > 16'(MFM_LINE_MAX)) begin
      det_code = MFM_CODE_SEQLINE;
    end else if (reg_access_stb && reg_number > reg_group_max) begin
      det_code = MFM_CODE_REGNUM;
    end else if (aux_fault_cfg[MFM_BUSTMO_EN_BIT] && tmo_ff >= 32'(BUS_TMO_CYC)) begin
      det_code = MFM_CODE_BUSTMO;
    end
  end

  // error latch: holds until the reset type the code needs
  logic [7:0] code_ff;
  logic [7:0] nxt_code;
  logic       hw_ff;
  logic       nxt_hw;
  logic       brake_ff;
  logic       nxt_brake;
  logic       act_ff;
  logic       nxt_act;
  always_comb begin
    nxt_code  = code_ff;
    nxt_hw    = hw_ff;
    nxt_brake = brake_ff;
    nxt_act   = act_ff;
    if (sw_reset && !hw_ff) begin
      nxt_code  = MFM_CODE_NONE;
      nxt_brake = 1'b0;
      nxt_act   = 1'b0;
    end
    // a new fault in the clear cycle still latches
    if (det_code != MFM_CODE_NONE && (!act_ff || (sw_reset && !hw_ff))) begin
      nxt_code  = det_code;
      nxt_hw    = det_hw;
      nxt_brake = det_brake;
      nxt_act   = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_ff  <= MFM_CODE_NONE;
      hw_ff    <= 1'b0;
      brake_ff <= 1'b0;
      act_ff   <= 1'b0;
    end else begin
      code_ff  <= nxt_code;
      hw_ff    <= nxt_hw;
      brake_ff <= nxt_brake;
      act_ff   <= nxt_act;
    end
  end
  assign error_code      = code_ff;
  assign fault_active    = act_ff;
  assign brake_engage    = brake_ff;
  assign hw_reset_needed = hw_ff;

  // assertions
  a_hw_code_holds: assert property (@(posedge clk_sys) disable iff (rst)
    hw_ff && act_ff |=> act_ff && $stable(error_code))
    else $error("hardware-reset fault was cleared");
  a_param_a_brake: assert property (@(posedge clk_sys) disable iff (rst)
    !act_ff && checked_param_a_bad |=> error_code == MFM_CODE_PARAMA && brake_engage)
    else $error("param a fault not posted with brake");
  a_param_b_brake: assert property (@(posedge clk_sys) disable iff (rst)
    !act_ff && !checked_param_a_bad && checked_param_b_bad
    |=> error_code == MFM_CODE_PARAMB && brake_engage && hw_reset_needed)
    else $error("param b fault not posted with brake");
  a_sw_clear: assert property (@(posedge clk_sys) disable iff (rst)
    act_ff && !hw_ff && sw_reset && det_code == MFM_CODE_NONE |=> !fault_active
    ##1 (error_code == MFM_CODE_NONE || fault_active))
    else $error("software reset did not clear");
  a_label_range: assert property (@(posedge clk_sys) disable iff (rst)
    !act_ff && det_code == MFM_CODE_LABEL |=> error_code == 8'h24 && !brake_engage)
    else $error("label error wrong");
  a_line_range: assert property (@(posedge clk_sys) disable iff (rst)
    exec_stb && exec_line == 16'h1ffe |-> det_code != MFM_CODE_SEQLINE)
    else $error("line 8190 flagged");
  a_node_dup: assert property (@(posedge clk_sys) disable iff (rst)
    !act_ff && bus_node_dup && !checked_param_a_bad && !checked_param_b_bad
    && !(stack_push && depth_ff >= MFM_STACK_DEPTH)
    |=> error_code == MFM_CODE_NODEDUP && brake_engage)
    else $error("node duplicate not posted");
  a_pwron_check: assert property (@(posedge clk_sys) disable iff (rst)
    power_on_input_check_cfg |-> det_code != MFM_CODE_PWRON)
    else $error("power-on fault despite cfg");
  a_limit_excl: assert property (@(posedge clk_sys) disable iff (rst)
    (index_homing_move || stop_limit_search_move) |-> det_code != MFM_CODE_LIMIT)
    else $error("limit fault during homing");
  a_bus_timeout: assert property (@(posedge clk_sys) disable iff (rst)
    !aux_fault_cfg[MFM_BUSTMO_EN_BIT] |=> tmo_ff == 32'h0 && det_code != MFM_CODE_BUSTMO)
    else $error("bus timeout while disabled");
endmodule // mfm_motion_fault_monitor
`default_nettype wire

//--- bench/mfm_far_model.sv
// Purpose: far-side model of sequence store and multi-axis bus master
// Assumes: one clock; bench controls are levels
// Notes:   bus command strobe every fourth cycle while running
`timescale 1ns/10ps
`default_nettype none
module mfm_far_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // bench control
  input  wire logic load_dup,
  input  wire logic erase,
  input  wire logic bus_run,
  // design side
  output logic      label_dup_def,
  output logic      bus_cmd_stb
);
  logic [1:0] cnt_ff;
  // stale duplicate label stays until the store is erased
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      label_dup_def <= 1'h0;
      cnt_ff        <= 2'h0;
    end else begin
      if (erase) label_dup_def <= 1'h0;
      else if (load_dup) label_dup_def <= 1'h1;
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
  // bus master sends one command every fourth cycle
  assign bus_cmd_stb = bus_run && (cnt_ff == 2'h3);
endmodule // mfm_far_model
`default_nettype wire

//--- bench/mfm_motion_fault_monitor_tb_top.sv
// Purpose: self-checking bench for the motion fault monitor
// Assumes: bus silence timeout shortened to 20 cycles
// Notes:   each task raises faults, checks the code, then clears it
`timescale 1ns/10ps
`default_nettype none
module mfm_motion_fault_monitor_tb_top;
  import mfm_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, sw_reset = 1'h0, digital_input_one = 1'h0;
  logic limit_switch_pin = 1'h0, fuse_broken_pin = 1'h0, power_on_input_check_cfg = 1'h1;
  logic power_on_req = 1'h0, move_active = 1'h0, index_homing_move = 1'h0;
  logic stop_limit_search_move = 1'h0, jump_call_stb = 1'h0, exec_stb = 1'h0;
  logic reg_access_stb = 1'h0, stack_push = 1'h0, stack_pop = 1'h0, bus_node_dup = 1'h0;
  logic checked_param_a_bad = 1'h0, checked_param_b_bad = 1'h0;
  logic load_dup = 1'h0, erase = 1'h0, bus_run = 1'h1;
  logic [7:0]  din_pins = 8'h00, limit_switch_cfg = 8'h00, aux_fault_cfg = 8'h00;
  logic [2:0]  motor_temp_din_sel = 3'h0;
  logic [15:0] jump_label = 16'h0, exec_line = 16'h0, reg_number = 16'h0;
  logic [15:0] reg_group_max = 16'h0040;
  logic [7:0]  error_code;
  logic        label_dup_def, bus_cmd_stb, fault_active, brake_engage, hw_reset_needed;
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  mfm_motion_fault_monitor #(.BUS_TMO_CYC(20)) dut_u (
    .clk_sys, .rst, .sw_reset, .digital_input_one, .din_pins, .limit_switch_pin,
    .fuse_broken_pin, .power_on_input_check_cfg, .limit_switch_cfg, .aux_fault_cfg,
    .motor_temp_din_sel, .power_on_req, .move_active, .index_homing_move,
    .stop_limit_search_move, .label_dup_def, .jump_call_stb, .jump_label, .exec_stb,
    .exec_line, .reg_access_stb, .reg_number, .reg_group_max, .stack_push, .stack_pop,
    .checked_param_a_bad, .checked_param_b_bad, .bus_cmd_stb, .bus_node_dup,
    .error_code, .fault_active, .brake_engage, .hw_reset_needed);
  mfm_far_model far_u (.clk_sys, .rst, .load_dup, .erase, .bus_run, .label_dup_def,
    .bus_cmd_stb);
  // clock and hang guard
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task wt(input int n); repeat (n) @(posedge clk_sys); endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // sample outputs mid-cycle, return on a rising edge
  task ex(input logic [7:0] c, input logic b, input logic h);
    @(negedge clk_sys);
    chk("error_code", c, error_code);
    chk("status", {5'h0, c != 8'h00, b, h},
        {5'h0, fault_active, brake_engage, hw_reset_needed});
    @(posedge clk_sys);
  endtask
  task swc(input logic [7:0] c, input logic b, input logic h); // software reset
    wt(4);
    sw_reset <= 1'h1;
    @(posedge clk_sys) sw_reset <= 1'h0;
    wt(2);
    ex(c, b, h);
  endtask
  task hwc; // hardware reset
    rst <= 1'h1;
    wt(2);
    rst <= 1'h0;
    wt(1);
    ex(MFM_CODE_NONE, 0, 0);
  endtask
  // one interpreter strobe: 0 jump, 1 execute, 2 register access
  task seq(input logic [1:0] k, input logic [15:0] v, input logic [7:0] c);
    jump_label <= v;
    exec_line <= v;
    reg_number <= v;
    jump_call_stb <= (k == 2'h0);
    exec_stb <= (k == 2'h1);
    reg_access_stb <= (k == 2'h2);
    @(posedge clk_sys) {jump_call_stb, exec_stb, reg_access_stb} <= 3'h0;
    wt(2);
    ex(c, 0, 0);
  endtask
  task t_pins;
    power_on_req <= 1'h1;
    wt(5);
    ex(MFM_CODE_NONE, 0, 0);
    power_on_input_check_cfg <= 1'h0;
    wt(5);
    ex(MFM_CODE_PWRON, 0, 0);
    power_on_req <= 1'h0;
    swc(MFM_CODE_NONE, 0, 0);
    motor_temp_din_sel <= 3'h5;
    din_pins <= 8'hdf;
    wt(5);
    ex(MFM_CODE_NONE, 0, 0);
    din_pins <= 8'h20;
    wt(5);
    ex(MFM_CODE_MOTTEMP, 0, 0);
    din_pins <= 8'h00;
    swc(MFM_CODE_NONE, 0, 0);
    fuse_broken_pin <= 1'h1;
    wt(5);
    ex(MFM_CODE_FUSE, 0, 0);
    fuse_broken_pin <= 1'h0;
    swc(MFM_CODE_NONE, 0, 0);
  endtask
  task t_limit;
    limit_switch_cfg <= 8'h01;
    move_active <= 1'h1;
    index_homing_move <= 1'h1;
    limit_switch_pin <= 1'h1;
    wt(5);
    ex(MFM_CODE_NONE, 0, 0);
    index_homing_move <= 1'h0;
    stop_limit_search_move <= 1'h1;
    wt(5);
    ex(MFM_CODE_NONE, 0, 0);
    stop_limit_search_move <= 1'h0;
    wt(5);
    ex(MFM_CODE_LIMIT, 0, 0);
    limit_switch_pin <= 1'h0;
    swc(MFM_CODE_NONE, 0, 0);
  endtask
  task t_seq;
    load_dup <= 1'h1;
    @(posedge clk_sys) load_dup <= 1'h0;
    wt(2);
    ex(MFM_CODE_DUPLAB, 0, 0);
    swc(MFM_CODE_DUPLAB, 0, 0);
    erase <= 1'h1;
    @(posedge clk_sys) erase <= 1'h0;
    swc(MFM_CODE_NONE, 0, 0);
    seq(2'h0, 16'h01ff, MFM_CODE_NONE);
    seq(2'h0, 16'h0200, MFM_CODE_LABEL);
    seq(2'h1, 16'h1fff, MFM_CODE_LABEL);
    swc(MFM_CODE_NONE, 0, 0);
    seq(2'h1, 16'h1ffe, MFM_CODE_NONE);
    seq(2'h1, 16'h1fff, MFM_CODE_SEQLINE);
    swc(MFM_CODE_NONE, 0, 0);
    seq(2'h2, 16'h0040, MFM_CODE_NONE);
    seq(2'h2, 16'h0041, MFM_CODE_REGNUM);
    swc(MFM_CODE_NONE, 0, 0);
  endtask
  task t_hard;
    stack_push <= 1'h1;
    wt(256);
    stack_push <= 1'h0;
    stack_pop <= 1'h1;
    @(posedge clk_sys) stack_pop <= 1'h0;
    seq(2'h3, 16'h0, MFM_CODE_NONE);
    stack_push <= 1'h1;
    @(posedge clk_sys) stack_push <= 1'h0;
    wt(1);
    ex(MFM_CODE_NONE, 0, 0);
    stack_push <= 1'h1;
    @(posedge clk_sys) stack_push <= 1'h0;
    wt(2);
    ex(MFM_CODE_STACK, 0, 1);
    swc(MFM_CODE_STACK, 0, 1);
    hwc();
    checked_param_a_bad <= 1'h1;
    bus_node_dup <= 1'h1;
    wt(2);
    ex(MFM_CODE_PARAMA, 1, 1);
    {checked_param_a_bad, bus_node_dup} <= 2'h0;
    swc(MFM_CODE_PARAMA, 1, 1);
    hwc();
    checked_param_b_bad <= 1'h1;
    wt(2);
    ex(MFM_CODE_PARAMB, 1, 1);
    checked_param_b_bad <= 1'h0;
    hwc();
    bus_node_dup <= 1'h1;
    wt(2);
    ex(MFM_CODE_NODEDUP, 1, 0);
    bus_node_dup <= 1'h0;
    swc(MFM_CODE_NONE, 0, 0);
  endtask
  task t_bus;
    aux_fault_cfg <= 8'h02;
    wt(60);
    ex(MFM_CODE_NONE, 0, 0);
    bus_run <= 1'h0;
    wt(25);
    ex(MFM_CODE_BUSTMO, 0, 0);
    aux_fault_cfg <= 8'h00;
    bus_run <= 1'h1;
    swc(MFM_CODE_NONE, 0, 0);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    wt(6);
    rst <= 1'h0;
    wt(2);
    t_pins();
    t_limit();
    t_seq();
    t_hard();
    t_bus();
    finish_test();
  end
endmodule // mfm_motion_fault_monitor_tb_top
`default_nettype wire
